// *** hdl/fpc_front_panel.sv ***
// fpc_front_panel: keys, lamps and display fields of the front panel
// assumes key pins are asynchronous, status and bus on core_clk_in
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module fpc_front_panel #(
  parameter int unsigned LONG_CYC  = fpc_pkg::LONG_PRESS_CYC,
  parameter int unsigned BLINK_CYC = fpc_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              arst_n_in,
  // key pins: up, down, left, right, reset
  input  wire logic [4:0]        keys_in,
  // unit status
  input  wire fpc_pkg::fpc_stat_s stat_in,
  // external transport commands
  input  wire logic              ext_cmd_valid_in,
  input  wire logic [1:0]        ext_cmd_code_in,
  // register port
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [31:0]            reg_rdata_out,
  // front panel
  output fpc_pkg::fpc_lamp_s     lamps_out,
  output fpc_pkg::fpc_disp_s     disp_out,
  // transport to source, settings apply
  output fpc_pkg::fpc_cmd_s      cmd_out,
  output logic                   apply_out,
  output logic [5:0][7:0]        values_out,
  // reinitialisation
  output logic                   host_bus_rst_out,
  output logic                   disp_rst_out
);

  typedef struct packed {
    fpc_pkg::fpc_mode_e             mode;
    logic [4:0]                     sync1;
    logic [4:0]                     sync2;
    logic [4:0]                     prev;
    logic [fpc_pkg::HOLD_W-1:0]     hold;
    logic                           long_done;
    logic [fpc_pkg::BLINK_W-1:0]    blink_cnt;
    logic                           blink;
    logic                           keys_en;
    logic [5:0][7:0]                pend;
    logic [5:0][7:0]                active;
    logic                           apply;
    logic                           key_pend;
    logic [1:0]                     key_code;
    fpc_pkg::fpc_cmd_s              cmd;
    fpc_pkg::fpc_lamp_s             lamps;
    fpc_pkg::fpc_disp_s             disp;
    logic [3:0]                     reinit;
    logic                           reinit_on;
    logic [31:0]                    rdata;
  } fpc_state_s;

  localparam logic [fpc_pkg::HOLD_W-1:0]  LONG_W  = fpc_pkg::HOLD_W'(LONG_CYC);
  localparam logic [fpc_pkg::BLINK_W-1:0] BLINK_W = fpc_pkg::BLINK_W'(BLINK_CYC - 1);

  fpc_state_s q;
  fpc_state_s d;

  function automatic fpc_state_s rst_state();
    fpc_state_s s;
    s         = '0;
    s.mode    = fpc_pkg::FPC_OPER;
    s.keys_en = 1'b1;
    return s;
  endfunction : rst_state

  function automatic logic [7:0] step_val(input logic [7:0] v, input logic up);
    logic signed [7:0] sv;
    sv = $signed(v);
    if (up && sv < fpc_pkg::VARI_MAX) begin
      sv = sv + 8'sh01;
    end else if (!up && sv > fpc_pkg::VARI_MIN) begin
      sv = sv - 8'sh01;
    end
    return $unsigned(sv);
  endfunction : step_val

  logic [4:0] press;
  logic [4:0] rel;
  logic       short_dn;
  logic       toggle;
  logic       blink_on;

  always_comb begin
    d         = q;
    press     = 5'h00;
    rel       = 5'h00;
    short_dn  = 1'b0;
    toggle    = 1'b0;
    blink_on  = q.blink;
    d.apply   = 1'b0;
    d.cmd     = '0;
    d.rdata   = 32'h0000_0000;

    // key pin synchronisers and edges
    d.sync1 = keys_in;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    press   = q.sync2 & ~q.prev;
    rel     = ~q.sync2 & q.prev;
    if (!q.keys_en) begin
      press[3:0] = 4'h0;
      rel[3:0]   = 4'h0;
    end

    // blink time base
    if (q.blink_cnt == BLINK_W) begin
      d.blink_cnt = '0;
      d.blink     = ~q.blink;
    end else begin
      d.blink_cnt = q.blink_cnt + 1'b1;
    end

    // down key hold timing
    if (q.sync2[fpc_pkg::KEY_DN] && q.keys_en) begin
      if (q.hold != LONG_W) begin
        d.hold = q.hold + 1'b1;
      end else if (!q.long_done) begin
        toggle      = 1'b1;
        d.long_done = 1'b1;
      end
    end else begin
      d.hold      = '0;
      d.long_done = 1'b0;
    end
    short_dn = rel[fpc_pkg::KEY_DN] & ~q.long_done;

    case (q.mode)
      fpc_pkg::FPC_OPER: begin
        if (toggle) begin
          d.mode           = fpc_pkg::FPC_SETUP;
          d.disp.menu_root = 3'h0;
          d.disp.menu_page = 4'h0;
          d.pend           = q.active;
        end else begin
          if (press[fpc_pkg::KEY_UP]) begin
            d.disp.line2_sel = (q.disp.line2_sel == fpc_pkg::L2_BLANK) ?
                               fpc_pkg::L2_LAST : q.disp.line2_sel - 3'h1;
          end else if (short_dn) begin
            d.disp.line2_sel = (q.disp.line2_sel == fpc_pkg::L2_LAST) ?
                               fpc_pkg::L2_BLANK : q.disp.line2_sel + 3'h1;
          end
          if (press[fpc_pkg::KEY_LT]) begin
            d.key_pend = 1'b1;
            d.key_code = fpc_pkg::CMD_STOP;
          end else if (press[fpc_pkg::KEY_RT]) begin
            d.key_pend = 1'b1;
            d.key_code = fpc_pkg::CMD_PLAY;
          end
        end
      end
      fpc_pkg::FPC_SETUP: begin
        if (toggle) begin
          d.mode   = fpc_pkg::FPC_OPER;
          d.active = q.pend;
          d.apply  = 1'b1;
        end else if (q.disp.menu_page == 4'h0) begin
          if (press[fpc_pkg::KEY_LT]) begin
            d.disp.menu_root = (q.disp.menu_root == 3'h0) ?
                               fpc_pkg::ROOT_LAST : q.disp.menu_root - 3'h1;
          end else if (press[fpc_pkg::KEY_RT]) begin
            d.disp.menu_root = (q.disp.menu_root == fpc_pkg::ROOT_LAST) ?
                               3'h0 : q.disp.menu_root + 3'h1;
          end
        end else if (press[fpc_pkg::KEY_LT] || press[fpc_pkg::KEY_RT]) begin
          d.pend[q.disp.menu_root] = step_val(q.pend[q.disp.menu_root],
                                              press[fpc_pkg::KEY_RT]);
        end
        if (!toggle && short_dn &&
            q.disp.menu_page != fpc_pkg::ROOT_PAGES[q.disp.menu_root]) begin
          d.disp.menu_page = q.disp.menu_page + 4'h1;
        end else if (!toggle && press[fpc_pkg::KEY_UP] && q.disp.menu_page != 4'h0) begin
          d.disp.menu_page = q.disp.menu_page - 4'h1;
        end
      end
      default: begin
        d.mode = fpc_pkg::FPC_OPER;
      end
    endcase

    // transport merge: external first, a key command waits for a cycle with no external command
    d.cmd.dest = stat_in.tc_source;
    if (ext_cmd_valid_in) begin
      d.cmd.valid = 1'b1;
      d.cmd.code  = ext_cmd_code_in;
    end else if (q.key_pend) begin
      d.cmd.valid = 1'b1;
      d.cmd.code  = q.key_code;
      d.key_pend  = d.key_pend & (press[fpc_pkg::KEY_LT] | press[fpc_pkg::KEY_RT]);
    end

    // lamps
    d.lamps.cursor = (d.mode == fpc_pkg::FPC_SETUP);
    d.lamps.frame  = stat_in.frame_locked | (stat_in.frame_locking & blink_on);
    d.lamps.clock  = stat_in.clk_present &
                     (stat_in.clk_locked | blink_on);
    d.lamps.link   = stat_in.link_up |
                     (stat_in.precise_on & (~stat_in.link_present | ~stat_in.link_synced) &
                      blink_on);

    // standard letter
    case (stat_in.tc_std)
      fpc_pkg::STD_25:   d.disp.std_char = 8'h50;
      fpc_pkg::STD_30ND: d.disp.std_char = 8'h4e;
      fpc_pkg::STD_30DF: d.disp.std_char = 8'h44;
      default:           d.disp.std_char = 8'h46;
    endcase

    // transport icon
    if (!stat_in.tc_locked) begin
      d.disp.xport_chars = 16'h213e;
    end else begin
      case (stat_in.xport)
        fpc_pkg::XP_PLAY: d.disp.xport_chars = 16'h3e20;
        fpc_pkg::XP_STOP: d.disp.xport_chars = 16'h5b5d;
        fpc_pkg::XP_REW:  d.disp.xport_chars = 16'h3c3c;
        fpc_pkg::XP_FF:   d.disp.xport_chars = 16'h3e3e;
        fpc_pkg::XP_JOG:  d.disp.xport_chars = 16'h4a67;
        fpc_pkg::XP_SHTL: d.disp.xport_chars = 16'h5368;
        default:          d.disp.xport_chars = 16'h2020;
      endcase
    end

    // host field, receiving shown over connected
    if (stat_in.host_rx) begin
      d.disp.host_char = 8'h2a;
    end else if (stat_in.host_up) begin
      d.disp.host_char = 8'h23;
    end else begin
      d.disp.host_char = 8'h20;
    end

    // frame and clock fields
    d.disp.frame_is_rate = stat_in.follow_frame;
    d.disp.frame_code    = stat_in.follow_frame ? stat_in.frame_rate :
                           {1'b0, stat_in.frame_ref};
    d.disp.clk_is_frame  = stat_in.follow_frame;
    d.disp.clk_code      = stat_in.follow_frame ? {1'b0, stat_in.frame_ref} :
                           stat_in.clk_sel;

    // rate field follows the applied varispeed value
    d.disp.pull_pct     = $signed(q.active[1]);
    d.disp.rate_is_pull = (q.active[1] != 8'h00);
    d.disp.rate_code    = stat_in.sample_rate;

    d.disp.no_machine = (d.disp.line2_sel == fpc_pkg::L2_SERIAL) &
                        ~stat_in.deck_answers;

    // register port
    if (reg_wr_in && reg_addr_in == fpc_pkg::REG_CTRL) begin
      d.keys_en = reg_wdata_in[0];
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        fpc_pkg::REG_CTRL: begin
          d.rdata[0] = q.keys_en;
        end
        fpc_pkg::REG_STATUS: begin
          d.rdata[fpc_pkg::ST_MODE_B]                   = (q.mode == fpc_pkg::FPC_SETUP);
          d.rdata[fpc_pkg::ST_L2_B +: 3]                = q.disp.line2_sel;
          d.rdata[fpc_pkg::ST_ROOT_B +: 3]              = q.disp.menu_root;
          d.rdata[fpc_pkg::ST_PAGE_B +: 4]              = q.disp.menu_page;
        end
        fpc_pkg::REG_VALUE: begin
          d.rdata[7:0]  = q.active[q.disp.menu_root];
          d.rdata[15:8] = q.pend[q.disp.menu_root];
        end
        fpc_pkg::REG_LAMPS: begin
          d.rdata[3:0] = q.lamps;
        end
        default: begin
          d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // reset key: controller back to power-up state, reinit pulses out
    if (q.reinit != 4'h0) begin
      d.reinit = q.reinit - 4'h1;
    end
    if (press[fpc_pkg::KEY_RS]) begin
      d        = rst_state();
      d.sync1  = keys_in;
      d.sync2  = q.sync1;
      d.prev   = q.sync2;
      d.reinit = fpc_pkg::REINIT_CYC;
    end
    // reinit outputs leave the block straight from a flop
    d.reinit_on = (d.reinit != 4'h0);
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= rst_state();
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_out    = q.rdata;
  assign lamps_out        = q.lamps;
  assign disp_out         = q.disp;
  assign cmd_out          = q.cmd;
  assign apply_out        = q.apply;
  assign values_out       = q.active;
  assign host_bus_rst_out = q.reinit_on;
  assign disp_rst_out     = q.reinit_on;

endmodule : fpc_front_panel

// *** hdl/fpc_pkg.sv ***
// fpc_pkg: constants, encodings and carriers of the front panel controller
// assumes one 25 MHz system clock shared by all users of these types
package fpc_pkg;

  // timing
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned LONG_PRESS_MS  = 1000;
  localparam int unsigned BLINK_HALF_MS  = 250;
  localparam int unsigned LONG_PRESS_CYC = (CLK_HZ / 1000) * LONG_PRESS_MS;
  localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam int unsigned HOLD_W         = 25;
  localparam int unsigned BLINK_W        = 23;
  localparam logic [3:0]  REINIT_CYC     = 4'hf;

  // key bit positions
  localparam int unsigned KEY_UP = 0;
  localparam int unsigned KEY_DN = 1;
  localparam int unsigned KEY_LT = 2;
  localparam int unsigned KEY_RT = 3;
  localparam int unsigned KEY_RS = 4;

  // menus: six roots, setting pages per root (unit..usb)
  localparam logic [2:0]      ROOT_LAST  = 3'h5;
  localparam logic [5:0][3:0] ROOT_PAGES = {4'h5, 4'h4, 4'h2, 4'h3, 4'hb, 4'h8};
  // values in 0.1 percent steps
  localparam logic signed [7:0] VARI_MAX = 8'sh7d;
  localparam logic signed [7:0] VARI_MIN = -8'sh7d;

  // line 2 views
  localparam logic [2:0] L2_BLANK  = 3'h0;
  localparam logic [2:0] L2_SERIAL = 3'h6;
  localparam logic [2:0] L2_LAST   = 3'h6;

  // transport commands and states
  localparam logic [1:0] CMD_STOP = 2'h1;
  localparam logic [1:0] CMD_PLAY = 2'h2;
  localparam logic [2:0] XP_PLAY  = 3'h0;
  localparam logic [2:0] XP_STOP  = 3'h1;
  localparam logic [2:0] XP_REW   = 3'h2;
  localparam logic [2:0] XP_FF    = 3'h3;
  localparam logic [2:0] XP_JOG   = 3'h4;
  localparam logic [2:0] XP_SHTL  = 3'h5;

  // timecode standards
  localparam logic [1:0] STD_25   = 2'h0;
  localparam logic [1:0] STD_30ND = 2'h1;
  localparam logic [1:0] STD_30DF = 2'h2;
  localparam logic [1:0] STD_24   = 2'h3;

  // register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_VALUE  = 8'h08;
  localparam logic [7:0] REG_LAMPS  = 8'h0c;
  localparam int unsigned ST_MODE_B = 0;
  localparam int unsigned ST_L2_B   = 1;
  localparam int unsigned ST_ROOT_B = 4;
  localparam int unsigned ST_PAGE_B = 7;

  typedef enum logic [1:0] {
    FPC_OPER  = 2'b01,
    FPC_SETUP = 2'b10
  } fpc_mode_e;

  // unit status, same clock
  typedef struct packed {
    logic       frame_locking;
    logic       frame_locked;
    logic       clk_present;
    logic       clk_locked;
    logic       link_up;
    logic       precise_on;
    logic       link_present;
    logic       link_synced;
    logic [1:0] tc_std;
    logic [2:0] xport;
    logic       tc_locked;
    logic       host_up;
    logic       host_rx;
    logic [1:0] frame_ref;
    logic       follow_frame;
    logic [2:0] frame_rate;
    logic [2:0] clk_sel;
    logic [1:0] sample_rate;
    logic       deck_answers;
    logic [2:0] tc_source;
  } fpc_stat_s;

  typedef struct packed {
    logic cursor;
    logic frame;
    logic clock;
    logic link;
  } fpc_lamp_s;

  typedef struct packed {
    logic [7:0]        std_char;
    logic [15:0]       xport_chars;
    logic [7:0]        host_char;
    logic              frame_is_rate;
    logic [2:0]        frame_code;
    logic              clk_is_frame;
    logic [2:0]        clk_code;
    logic              rate_is_pull;
    logic [1:0]        rate_code;
    logic signed [7:0] pull_pct;
    logic              no_machine;
    logic [2:0]        line2_sel;
    logic [2:0]        menu_root;
    logic [3:0]        menu_page;
  } fpc_disp_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] code;
    logic [2:0] dest;
  } fpc_cmd_s;

endpackage : fpc_pkg

// *** dv/fpc_front_panel_asserts.sv ***
// fpc_front_panel_asserts: port-level checks of the front panel controller
// assumes binding onto fpc_front_panel, one clock domain
`timescale 1ns/1ps
module fpc_front_panel_asserts #(
  parameter int unsigned LONG_CYC  = 50,
  parameter int unsigned BLINK_CYC = 8
) (
  // clock and reset
  input wire logic               core_clk_in,
  input wire logic               arst_n_in,
  // watched inputs
  input wire fpc_pkg::fpc_stat_s stat_in,
  input wire logic               ext_cmd_valid_in,
  input wire logic [1:0]         ext_cmd_code_in,
  // watched outputs
  input wire fpc_pkg::fpc_lamp_s lamps_out,
  input wire fpc_pkg::fpc_disp_s disp_out,
  input wire fpc_pkg::fpc_cmd_s  cmd_out,
  input wire logic               apply_out,
  input wire logic [5:0][7:0]    values_out,
  input wire logic               host_bus_rst_out,
  input wire logic               disp_rst_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  function automatic logic [7:0] std_letter(input logic [1:0] s);
    return (s == fpc_pkg::STD_25) ? 8'h50 : (s == fpc_pkg::STD_30ND) ? 8'h4e :
           (s == fpc_pkg::STD_30DF) ? 8'h44 : 8'h46;
  endfunction : std_letter

  chk_ext_cmd_fwd: assert property (ext_cmd_valid_in |=> cmd_out.valid && cmd_out.code == $past(ext_cmd_code_in))
    else $error("external command not forwarded");
  chk_cmd_dest: assert property (cmd_out.valid |-> cmd_out.dest == $past(stat_in.tc_source))
    else $error("command sent to wrong source");
  // fields and lamps read blank for one cycle after power reset and after the reset key
  chk_std_letter: assert property ($past(arst_n_in) && !$rose(host_bus_rst_out) |->
    disp_out.std_char == std_letter($past(stat_in.tc_std))) else $error("wrong standard letter");
  chk_host_char: assert property ($past(arst_n_in) && !$rose(host_bus_rst_out) |->
    disp_out.host_char == ($past(stat_in.host_rx) ? 8'h2a : $past(stat_in.host_up) ? 8'h23 : 8'h20))
    else $error("wrong host field");
  chk_link_steady: assert property ($past(arst_n_in) && !$rose(host_bus_rst_out) &&
    $past(stat_in.link_up) |-> lamps_out.link) else $error("link lamp not steady");
  chk_follow_fields: assert property ($past(arst_n_in) && !$rose(host_bus_rst_out) |->
    disp_out.frame_is_rate == $past(stat_in.follow_frame) &&
    disp_out.clk_is_frame == $past(stat_in.follow_frame)) else $error("follow fields wrong");
  chk_entry_root: assert property ($rose(lamps_out.cursor) |-> disp_out.menu_root == 3'h0
    && disp_out.menu_page == 4'h0) else $error("settings entry not at root");
  chk_apply_exit: assert property (apply_out |-> $fell(lamps_out.cursor))
    else $error("apply without leaving settings");
  chk_values_hold: assert property (!apply_out && $changed(values_out) |-> ##[0:1] host_bus_rst_out)
    else $error("values changed without apply");
  chk_vari_range: assert property ($signed(values_out[1]) <= 125 && $signed(values_out[1]) >= -125)
    else $error("varispeed out of range");
  chk_no_machine: assert property (disp_out.no_machine == (disp_out.line2_sel == fpc_pkg::L2_SERIAL
    && !$past(stat_in.deck_answers))) else $error("no machine flag wrong");
  chk_reinit_len: assert property ($rose(host_bus_rst_out) |-> (host_bus_rst_out && disp_rst_out)[*8]
    ##1 (host_bus_rst_out && disp_rst_out)[*7] ##1 !host_bus_rst_out) else $error("reinit pulse length");
endmodule : fpc_front_panel_asserts

// *** dv/fpc_operator.sv ***
// fpc_operator: operator at the key pins of the front panel
// assumes keys read high while pressed, low when up
`timescale 1ns/1ps
module fpc_operator (
  // clock
  input  wire logic core_clk_in,
  // key pins
  output logic [4:0] keys_out
);
  initial keys_out = 5'h00;
  // hold one key, then leave the panel alone until it settles
  task automatic press(input int unsigned k, input int unsigned hold_cyc);
    @(posedge core_clk_in);
    keys_out[k] <= 1'b1;
    repeat (hold_cyc) @(posedge core_clk_in);
    keys_out[k] <= 1'b0;
    repeat (8) @(posedge core_clk_in);
  endtask : press
endmodule : fpc_operator

// *** dv/testbench.sv ***
// testbench: register, key, lamp and display scenarios of the front panel
// assumes fpc_front_panel with shortened long press and blink counts
`timescale 1ns/1ps
module testbench;
  localparam int unsigned LONG  = 50;
  localparam int unsigned BLINK = 8;
  logic               clk;
  logic               rst_n;
  logic [4:0]         keys;
  fpc_pkg::fpc_stat_s stat;
  logic               ext_v;
  logic [1:0]         ext_c;
  logic [7:0]         addr;
  logic [31:0]        wdata;
  logic               wr;
  logic               rd;
  logic [31:0]        rdata;
  fpc_pkg::fpc_lamp_s lamps;
  fpc_pkg::fpc_disp_s disp;
  fpc_pkg::fpc_cmd_s  cmd;
  logic               apply;
  logic [5:0][7:0]    values;
  logic               hb_rst;
  logic               d_rst;
  int                 n_errors;
  int                 samples_checked;
  logic [31:0]        d;
  logic [7:0]         std_tab [4] = '{8'h50, 8'h4e, 8'h44, 8'h46};
  logic [15:0]        xp_tab [6] = '{16'h3e20, 16'h5b5d, 16'h3c3c, 16'h3e3e, 16'h4a67, 16'h5368};

  fpc_operator u_op (.core_clk_in(clk), .keys_out(keys));
  fpc_front_panel #(.LONG_CYC(LONG), .BLINK_CYC(BLINK)) DUT (
    .core_clk_in(clk), .arst_n_in(rst_n), .keys_in(keys), .stat_in(stat),
    .ext_cmd_valid_in(ext_v), .ext_cmd_code_in(ext_c), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .lamps_out(lamps), .disp_out(disp),
    .cmd_out(cmd), .apply_out(apply), .values_out(values), .host_bus_rst_out(hb_rst), .disp_rst_out(d_rst));

  always #20 clk = ~clk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask : settle
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : reg_read
  // watch for one transport command while the operator or a source sends it
  task automatic wait_cmd(input logic [1:0] code, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (16) begin
      @(negedge clk);
      if (cmd.valid === 1'b1 && !seen) begin
        seen = 1'b1;
        check("cmd_code", code, cmd.code);
        check("cmd_dest", 3'h5, cmd.dest);
      end
    end
    check("cmd_seen", exp, seen);
  endtask : wait_cmd
  task automatic key_cmd(input int unsigned k, input logic [1:0] code, input logic exp);
    fork
      u_op.press(k, 4);
      wait_cmd(code, exp);
    join
  endtask : key_cmd
  task automatic lamp_watch(input string what, input int unsigned idx, input logic blink);
    logic saw0;
    logic saw1;
    saw0 = 1'b0;
    saw1 = 1'b0;
    repeat (4 * BLINK + 4) begin
      @(negedge clk);
      saw0 |= (lamps[idx] === 1'b0);
      saw1 |= (lamps[idx] === 1'b1);
    end
    check(what, blink ? 2'b11 : 2'b10, {saw1, saw0});
  endtask : lamp_watch

  initial begin
    #2000000;
    n_errors++;
    $display("Error watchdog expired");
    stop_test();
  end

  initial begin
    clk = 1'b0; rst_n = 1'b0; stat = '0; ext_v = 1'b0; ext_c = 2'h0;
    addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0; n_errors = 0; samples_checked = 0;
    stat.tc_source = 3'h5; stat.link_up = 1'b1; stat.host_up = 1'b1; stat.tc_locked = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(fpc_pkg::REG_CTRL, d);
    check("ctrl", 32'h1, d);
    reg_read(fpc_pkg::REG_STATUS, d);
    check("status", 32'h0, d);
    reg_read(8'h10, d);
    check("unmapped", 32'h0, d);
    $display("test registers done");
    key_cmd(fpc_pkg::KEY_LT, fpc_pkg::CMD_STOP, 1'b1);
    key_cmd(fpc_pkg::KEY_RT, fpc_pkg::CMD_PLAY, 1'b1);
    @(posedge clk);
    ext_v <= 1'b1;
    ext_c <= fpc_pkg::CMD_STOP;
    @(posedge clk);
    ext_v <= 1'b0;
    wait_cmd(fpc_pkg::CMD_STOP, 1'b1);
    reg_write(fpc_pkg::REG_CTRL, 32'h0);
    key_cmd(fpc_pkg::KEY_LT, fpc_pkg::CMD_STOP, 1'b0);
    reg_write(fpc_pkg::REG_CTRL, 32'h1);
    $display("test transport done");
    u_op.press(fpc_pkg::KEY_DN, 4);
    check("line2_dn", 3'h1, disp.line2_sel);
    check("cursor_oper", 1'b0, lamps.cursor);
    u_op.press(fpc_pkg::KEY_UP, 4);
    u_op.press(fpc_pkg::KEY_UP, 4);
    check("line2_wrap", fpc_pkg::L2_SERIAL, disp.line2_sel);
    check("no_machine", 1'b1, disp.no_machine);
    $display("test line two done");
    u_op.press(fpc_pkg::KEY_DN, LONG + 10);
    check("cursor_setup", 1'b1, lamps.cursor);
    check("entry_root", 3'h0, disp.menu_root);
    u_op.press(fpc_pkg::KEY_RT, 4);
    u_op.press(fpc_pkg::KEY_RT, 4);
    check("root_right", 3'h2, disp.menu_root);
    u_op.press(fpc_pkg::KEY_LT, 4);
    u_op.press(fpc_pkg::KEY_DN, 4);
    check("page_down", {3'h1, 4'h1}, {disp.menu_root, disp.menu_page});
    repeat (127) u_op.press(fpc_pkg::KEY_RT, 2);
    reg_read(fpc_pkg::REG_VALUE, d);
    check("pending_clamp", 32'h7d00, d);
    check("not_applied", 8'h00, values[1]);
    u_op.press(fpc_pkg::KEY_UP, 4);
    check("page_up", 4'h0, disp.menu_page);
    u_op.press(fpc_pkg::KEY_DN, LONG + 10);
    check("cursor_back", 1'b0, lamps.cursor);
    check("applied", 8'h7d, values[1]);
    check("pull_field", {1'b1, 8'h7d}, {disp.rate_is_pull, disp.pull_pct});
    check("long_no_short", fpc_pkg::L2_SERIAL, disp.line2_sel);
    $display("test settings done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      stat.tc_std <= 2'(i);
      settle();
      check("std_char", std_tab[i], disp.std_char);
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      stat.xport <= 3'(i);
      settle();
      check("xport_icon", xp_tab[i], disp.xport_chars);
    end
    @(posedge clk);
    stat.tc_locked   <= 1'b0;
    stat.follow_frame <= 1'b1;
    stat.host_rx     <= 1'b1;
    stat.deck_answers <= 1'b1;
    stat.frame_rate  <= 3'h4;
    stat.frame_ref   <= 2'h2;
    settle();
    check("frame_codes", {3'h4, 3'h2}, {disp.frame_code, disp.clk_code});
    check("not_locked", 16'h213e, disp.xport_chars);
    check("follow", 2'b11, {disp.frame_is_rate, disp.clk_is_frame});
    check("host_rx", 8'h2a, disp.host_char);
    check("deck_ok", 1'b0, disp.no_machine);
    $display("test display done");
    @(posedge clk);
    stat.frame_locking <= 1'b1;
    stat.clk_present   <= 1'b1;
    stat.link_up       <= 1'b0;
    stat.precise_on    <= 1'b1;
    lamp_watch("frame_blink", 2, 1'b1);
    lamp_watch("clock_blink", 1, 1'b1);
    lamp_watch("link_blink", 0, 1'b1);
    @(posedge clk);
    stat.frame_locking <= 1'b0;
    stat.frame_locked  <= 1'b1;
    stat.clk_locked    <= 1'b1;
    stat.link_up       <= 1'b1;
    settle();
    lamp_watch("frame_solid", 2, 1'b0);
    lamp_watch("clock_solid", 1, 1'b0);
    lamp_watch("link_solid", 0, 1'b0);
    $display("test lamps done");
    u_op.press(fpc_pkg::KEY_DN, LONG + 10);
    u_op.press(fpc_pkg::KEY_RS, 4);
    check("reinit_host", 1'b1, hb_rst);
    check("reinit_disp", 1'b1, d_rst);
    repeat (20) @(negedge clk);
    check("reset_values", 8'h00, values[1]);
    check("reset_cursor", 1'b0, lamps.cursor);
    $display("test reset key done");
    stop_test();
  end
endmodule : testbench

bind fpc_front_panel fpc_front_panel_asserts #(.LONG_CYC(LONG_CYC), .BLINK_CYC(BLINK_CYC)) u_chk (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .stat_in(stat_in), .ext_cmd_valid_in(ext_cmd_valid_in),
  .ext_cmd_code_in(ext_cmd_code_in), .lamps_out(lamps_out), .disp_out(disp_out), .cmd_out(cmd_out),
  .apply_out(apply_out), .values_out(values_out), .host_bus_rst_out(host_bus_rst_out),
  .disp_rst_out(disp_rst_out));
